// ==== logic/lpr_ctrl.sv ====
// Host-side read controller for a byte-wide asynchronous low-power memory.
// Assumes the memory pins are driven straight from here; the data pins are
// inputs sampled synchronously to the 40 MHz clock.
`timescale 1ns/1ps
module lpr_ctrl
    import lpr_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int DATA_WIDTH = DATA_W
) (
    input  wire logic                  clk_in,
    input  wire logic                  arst_n_in,
    // User side.
    input  wire logic                  req_valid_in,
    input  wire logic [ADDR_WIDTH-1:0] req_addr_in,
    input  wire logic                  req_hold_oe_in,
    output logic                       req_ready_out,
    output logic                       rsp_valid_out,
    output logic [DATA_WIDTH-1:0]      rsp_data_out,
    output logic [1:0]                 rsp_kind_out,
    // Memory side.
    output logic                       first_select_low_out,
    output logic                       second_select_high_out,
    output logic                       oe_n_out,
    output logic                       we_n_out,
    output logic [ADDR_WIDTH-1:0]      addr_out,
    input  wire logic [DATA_WIDTH-1:0] dq_in,
    output logic [DATA_WIDTH-1:0]      dq_out,
    output logic                       dq_oe_out
);

    // -------------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------------
    if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W) begin : g_bad_width
        $error("lpr_ctrl serves only the documented widths");
    end

    // Every wait is loaded into a CNT_W-bit timer, so each must fit there.
    if (ADDR_CYC >= (1 << CNT_W) || SEL_CYC >= (1 << CNT_W) || OE_CYC >= (1 << CNT_W)
        || SETUP_CYC >= (1 << CNT_W) || PERIOD_CYC >= (1 << CNT_W)) begin : g_bad_count
        $error("lpr_ctrl timer too narrow for the access waits");
    end

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    lpr_state_t            state_ff;
    lpr_state_t            nxt_state;
    logic                  sel_ff;
    logic                  oe_ff;
    logic [ADDR_WIDTH-1:0] addr_ff;
    logic [DATA_WIDTH-1:0] data_ff;
    logic                  rsp_valid_ff;
    lpr_kind_t             kind_ff;
    logic                  tmr_load;
    logic [CNT_W-1:0]      tmr_count;
    logic                  tmr_done;
    logic                  period_load;
    logic                  period_done;
    logic                  take;
    logic                  addr_step;

    // -------------------------------------------------------------------------
    // Timers
    // -------------------------------------------------------------------------
    // Access timer and read-period spacing timer.
    lpr_timer u_access (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .load_in   (tmr_load),
        .count_in  (tmr_count),
        .done_out  (tmr_done)
    );

    lpr_timer u_period (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .load_in   (period_load),
        .count_in  (CNT_W'(PERIOD_CYC)),
        .done_out  (period_done)
    );

    // -------------------------------------------------------------------------
    // Request handshake
    // -------------------------------------------------------------------------
    // A take of a new address in the done state while still selected is an address step, even when
    // the hold level has just dropped; the deselect only happens on an idle cycle.
    // A request is taken when idle, or between reads while the memory stays selected.
    assign req_ready_out = ((state_ff == LPR_IDLE) || (state_ff == LPR_DONE)) && period_done;
    assign take          = req_valid_in && req_ready_out;
    // Stepping the address while selected gives an address-initiated read.
    assign addr_step     = take && sel_ff && (req_addr_in != addr_ff);

    // Next-state and timer loading.
    always_comb begin
        nxt_state   = state_ff;
        tmr_load    = 1'b0;
        tmr_count   = '0;
        period_load = 1'b0;
        case (state_ff)
            LPR_IDLE, LPR_DONE: begin
                if (take && addr_step) begin
                    nxt_state   = LPR_ADDRWT;
                    tmr_load    = 1'b1;
                    tmr_count   = CNT_W'(ADDR_CYC);
                    period_load = 1'b1;
                end else if (take && sel_ff) begin
                    // Same address while selected: no new trigger, data already held.
                    nxt_state = LPR_DONE;
                end else if (take) begin
                    nxt_state = LPR_SETUP;
                    tmr_load  = 1'b1;
                    tmr_count = CNT_W'(SETUP_CYC);
                end else if (!req_hold_oe_in && state_ff == LPR_DONE) begin
                    nxt_state = LPR_IDLE;
                end
            end
            LPR_SETUP: begin
                // Address has settled; selection now triggers a single sense.
                if (tmr_done) begin
                    nxt_state   = LPR_SELWT;
                    tmr_load    = 1'b1;
                    tmr_count   = CNT_W'(SEL_CYC);
                    period_load = 1'b1;
                end
            end
            LPR_SELWT, LPR_ADDRWT: begin
                // Access done; the output-enable delay then follows as its own access.
                if (tmr_done) begin
                    nxt_state = LPR_OEWT;
                    tmr_load  = 1'b1;
                    tmr_count = CNT_W'(OE_CYC);
                end
            end
            LPR_OEWT: begin
                if (tmr_done) begin
                    nxt_state = LPR_DONE;
                end
            end
            default: begin
                nxt_state = LPR_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    // State register.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= LPR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Address is loaded once per taken request and held stable otherwise.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            addr_ff <= ADDR_RST;
        end else if (take) begin
            addr_ff <= req_addr_in;
        end
    end

    // Selection asserts after the address setup and drops when the host goes idle.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_ff <= 1'b0;
        end else if (state_ff == LPR_SETUP && tmr_done) begin
            sel_ff <= 1'b1;
        end else if (nxt_state == LPR_IDLE) begin
            sel_ff <= 1'b0;
        end
    end

    // Output enable is kept low through address reads so data stays driven.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            oe_ff <= 1'b0;
        end else if (state_ff == LPR_SELWT && tmr_done) begin
            oe_ff <= 1'b1;
        end else if (nxt_state == LPR_IDLE) begin
            oe_ff <= 1'b0;
        end
    end

    // Read data is captured after the output-enable delay, or at once on a same-address take while selected.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_ff      <= DATA_RST;
            rsp_valid_ff <= 1'b0;
            kind_ff      <= LPR_KIND_SEL;
        end else begin
            rsp_valid_ff <= 1'b0;
            if (take) begin
                kind_ff <= addr_step ? LPR_KIND_ADDR : (sel_ff ? LPR_KIND_OE : LPR_KIND_SEL);
            end
            if ((state_ff == LPR_OEWT && tmr_done) || (take && sel_ff && !addr_step)) begin
                data_ff      <= dq_in;
                rsp_valid_ff <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Memory pins and answer
    // -------------------------------------------------------------------------
    // Pins: both selects drive together, write strobe held inactive.
    // The host never writes, so its data driver stays off for good.
    assign first_select_low_out   = !sel_ff;
    assign second_select_high_out = sel_ff;
    assign oe_n_out               = !oe_ff;
    assign we_n_out               = 1'b1;
    assign addr_out               = addr_ff;
    assign dq_out                 = DATA_RST;
    assign dq_oe_out              = 1'b0;

    // User answer straight from its registers.
    assign rsp_valid_out          = rsp_valid_ff;
    assign rsp_data_out           = data_ff;
    assign rsp_kind_out           = kind_ff;

endmodule // lpr_ctrl

// ==== logic/lpr_pkg.sv ====
// Constants, states and timing figures for the low-power memory read controller.
// Assumes a 40 MHz clock; all times are converted to whole clock cycles here.
//
// How it works
// - Selected before address change: address-initiated read
// - Address stable before selection: selection-initiated read
// - Output-enable read needs a completed access
// - Address read: change address, selected, oe, no write
// - New address at most once per read period
// - Sequential reads step address while selected
// - Address stays stable through selection read
// - Output-enable read waits oe-to-data or pending delays
package lpr_pkg;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int CLK_PERIOD_PS          = 25000;
    localparam int ADDRESS_TO_DATA_PS     = 15000;
    localparam int MIN_READ_PERIOD_PS     = 15000;
    localparam int SELECT_TO_DATA_PS      = 15000;
    localparam int OE_TO_DATA_PS          = 7000;
    localparam int TRIGGER_WINDOW_PS      = 5000;
    // Least times round up to whole cycles, never below one.
    localparam int ADDR_CYC   = (ADDRESS_TO_DATA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PERIOD_CYC = (MIN_READ_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEL_CYC    = (SELECT_TO_DATA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OE_CYC     = (OE_TO_DATA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Cycles the address must settle before selection goes active.
    localparam int SETUP_CYC  = (TRIGGER_WINDOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W      = 4;

    // -------------------------------------------------------------------------
    // Widths and states
    // -------------------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h0_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        LPR_IDLE   = 3'b000,
        LPR_SETUP  = 3'b001,
        LPR_SELWT  = 3'b010,
        LPR_ADDRWT = 3'b011,
        LPR_OEWT   = 3'b100,
        LPR_DONE   = 3'b101
    } lpr_state_t;

    typedef enum logic [1:0] {
        LPR_KIND_SEL  = 2'b00,
        LPR_KIND_ADDR = 2'b01,
        LPR_KIND_OE   = 2'b10
    } lpr_kind_t;

endpackage

// ==== logic/lpr_timer.sv ====
// Down-counter that flags when a loaded number of cycles has elapsed.
// Assumes the single 40 MHz clock and asynchronous active-low reset.
`timescale 1ns/1ps
module lpr_timer
    import lpr_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] count_in,
    output logic                  done_out
);

    logic [CNT_W-1:0] cnt_ff;

    // Loads a count and runs down to zero.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff <= '0;
        end else if (load_in) begin
            cnt_ff <= count_in;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // Elapsed when at most one count is left, so a load of N waits exactly N edges.
    // Done does not look at the load, since the load itself is decided from done.
    assign done_out = (cnt_ff[CNT_W-1:1] == '0);

endmodule // lpr_timer

// ==== testbench/lpr_ctrl_chk.sv ====
// Checker for the read controller's memory pins and user answers.
// Assumes it is bound to lpr_ctrl with one clock and an async reset.
`timescale 1ns/1ps
module lpr_ctrl_chk
    import lpr_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int DATA_WIDTH = DATA_W
) (
    input wire logic                  clk_in,
    input wire logic                  arst_n_in,
    input wire logic                  req_valid_in,
    input wire logic [ADDR_WIDTH-1:0] req_addr_in,
    input wire logic                  req_hold_oe_in,
    input wire logic                  req_ready_out,
    input wire logic                  rsp_valid_out,
    input wire logic [DATA_WIDTH-1:0] rsp_data_out,
    input wire logic [1:0]            rsp_kind_out,
    input wire logic                  first_select_low_out,
    input wire logic                  second_select_high_out,
    input wire logic                  oe_n_out,
    input wire logic                  we_n_out,
    input wire logic [ADDR_WIDTH-1:0] addr_out,
    input wire logic [DATA_WIDTH-1:0] dq_in,
    input wire logic [DATA_WIDTH-1:0] dq_out,
    input wire logic                  dq_oe_out
);
    logic sel;
    logic take;
    // Decoded selection and request acceptance.
    assign sel  = !first_select_low_out && second_select_high_out;
    assign take = req_valid_in && req_ready_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    a_no_write: assert property (we_n_out && !dq_oe_out) else $error("write strobe or data driver active");
    a_oe_needs_sel: assert property (!oe_n_out |-> sel) else $error("output enable without selection");
    a_sel_read: assert property (take && !sel |-> ##4 rsp_valid_out && rsp_kind_out == LPR_KIND_SEL)
        else $error("selection read answer late or wrong kind");
    a_step_read: assert property (take && sel && req_addr_in != addr_out
        |-> ##3 rsp_valid_out && rsp_kind_out == LPR_KIND_ADDR) else $error("address read answer wrong");
    a_held_read: assert property (take && sel && req_addr_in == addr_out
        |=> rsp_valid_out && rsp_kind_out == LPR_KIND_OE) else $error("held data answer wrong");
    a_addr_cause: assert property ($changed(addr_out) |-> $past(take) && addr_out == $past(req_addr_in))
        else $error("address moved without a request");
    a_addr_before_sel: assert property ($rose(sel) |-> $stable(addr_out))
        else $error("address switched with selection");
    a_step_spacing: assert property (take && req_addr_in != addr_out |=> !req_ready_out)
        else $error("new address inside read period");
    c_sel: cover property (take && !sel);
    c_step: cover property (take && sel && req_addr_in != addr_out);
    c_held: cover property (take && sel && req_addr_in == addr_out);
endmodule // lpr_ctrl_chk

bind lpr_ctrl lpr_ctrl_chk #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_chk (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in), .req_addr_in(req_addr_in),
    .req_hold_oe_in(req_hold_oe_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .rsp_kind_out(rsp_kind_out), .first_select_low_out(first_select_low_out),
    .second_select_high_out(second_select_high_out), .oe_n_out(oe_n_out), .we_n_out(we_n_out),
    .addr_out(addr_out), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out));

// ==== testbench/lpr_mem_model.sv ====
// Behavioural low-power byte memory that senses only on read triggers.
// Assumes pins straight from the controller; times are in nanoseconds.
`timescale 1ns/1ps
module lpr_mem_model (
    input  wire logic        first_select_low_in,
    input  wire logic        second_select_high_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [18:0] addr_in,
    output logic      [7:0]  dq_out
);
    logic       sel;
    logic       sense = 1'b0;
    logic [7:0] held  = 8'h00;
    // Selected only with the low select low and the high select high.
    assign sel = !first_select_low_in && second_select_high_in;
    // One trigger process merges selection and address events into one sense.
    always @(posedge sel or addr_in) begin
        if (sel && we_n_in) begin
            sense = 1'b1;
            sense <= #5 1'b0;
            held <= #15 addr_in[7:0] ^ addr_in[18:11];
        end
    end
    // Held data shows only under output enable; a released bus shows the inverse.
    assign dq_out = (sel && !oe_n_in && we_n_in) ? held : ~held;
endmodule // lpr_mem_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the low-power memory read controller.
// Assumes the memory model on the far side and a 40 MHz clock.
`timescale 1ns/1ps
module testbench
    import lpr_pkg::*;
();
    logic        clk_in;
    logic        arst_n_in;
    logic        req_valid_in;
    logic [18:0] req_addr_in;
    logic        req_hold_oe_in;
    logic        req_ready_out;
    logic        rsp_valid_out;
    logic [7:0]  rsp_data_out;
    logic [1:0]  rsp_kind_out;
    logic        sel_low;
    logic        sel_high;
    logic        oe_n;
    logic        we_n;
    logic [18:0] addr;
    logic [7:0]  dq_w;
    logic [7:0]  dq_o;
    logic        dq_oe;
    int          error_cnt  = 0;
    int          num_checks = 0;
    lpr_ctrl u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in),
        .req_addr_in(req_addr_in), .req_hold_oe_in(req_hold_oe_in), .req_ready_out(req_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .rsp_kind_out(rsp_kind_out),
        .first_select_low_out(sel_low), .second_select_high_out(sel_high), .oe_n_out(oe_n),
        .we_n_out(we_n), .addr_out(addr), .dq_in(dq_w), .dq_out(dq_o), .dq_oe_out(dq_oe));
    lpr_mem_model u_mem (.first_select_low_in(sel_low), .second_select_high_in(sel_high),
        .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(addr), .dq_out(dq_w));
    // Free-running 40 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Compares one value and reports a mismatch.
    task automatic chk_vec(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Issues one read and checks latency, data and kind of the answer.
    task automatic do_read(input logic [18:0] a, input logic hold, input logic [1:0] kind, input int lat);
        int n;
        n = 0;
        while (req_ready_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        req_valid_in   = 1'b1;
        req_addr_in    = a;
        req_hold_oe_in = hold;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        n = 1;
        while (rsp_valid_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        chk_vec(19'(n), 19'(lat));
        chk_vec({11'h000, rsp_data_out}, {11'h000, a[7:0] ^ a[18:11]});
        chk_vec({17'h0_0000, rsp_kind_out}, {17'h0_0000, kind});
    endtask
    // Reset state of pins and handshake.
    task automatic t_reset();
        chk_vec({12'h000, sel_low, sel_high, oe_n, we_n, dq_oe, rsp_valid_out, req_ready_out}, 19'h0_0059);
        chk_vec(addr, 19'h0_0000);
    endtask
    // Selection reads at both address extremes, then release of the selects.
    task automatic t_sel_read();
        do_read(19'h0_0000, 1'b0, LPR_KIND_SEL, 4);
        // One idle cycle lets the released read deselect before the next one.
        @(negedge clk_in);
        do_read(19'h7_FFFF, 1'b0, LPR_KIND_SEL, 4);
        repeat (3) @(negedge clk_in);
        chk_vec({17'h0_0000, sel_low, sel_high}, 19'h0_0002);
    endtask
    // Back-to-back address steps while selected, then two held-data reads.
    task automatic t_steps();
        logic [18:0] steps [3];
        steps = '{19'h1_2346, 19'h5_5555, 19'h2_AAAA};
        do_read(19'h1_2345, 1'b1, LPR_KIND_SEL, 4);
        foreach (steps[i]) do_read(steps[i], 1'b1, LPR_KIND_ADDR, 3);
        do_read(19'h2_AAAA, 1'b1, LPR_KIND_OE, 1);
        do_read(19'h2_AAAA, 1'b0, LPR_KIND_OE, 1);
        repeat (3) @(negedge clk_in);
        chk_vec({17'h0_0000, sel_low, sel_high}, 19'h0_0002);
    endtask
    // Cuts a hung run short.
    initial begin
        #(25 * 2000);
        error_cnt++;
        close_out();
    end
    // Main sequence: reset for 12 cycles, then the scenarios.
    initial begin
        arst_n_in      = 1'b0;
        req_valid_in   = 1'b0;
        req_addr_in    = 19'h0_0000;
        req_hold_oe_in = 1'b0;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        arst_n_in = 1'b1;
        t_reset();
        t_sel_read();
        t_steps();
        close_out();
    end
endmodule // testbench
